// file: energy_detect_power_control.sv
// What this block does
// - power management acts only while the enable bit 15 is set; resets to zero
// - automatic power-up bit 14 starts power-up once data count reaches threshold
// - automatic power-down bit 13 starts power-down when no line energy is seen
// - writing one to bit 12 starts a power change; the bit clears itself
// - a manual request toggles the power state regardless of counts or timer
// - a power-up with no burst still running sends a burst of four data pulses by default
// - burst-disable bit 11 reduces that to a single pulse per power-up
// - read-only bit 10 reads one when powered up, zero when powered down
// - bit 10 is meaningless while disabled; it reads zero then
// - bit 9 flags error threshold reached, clears on read, no power action
// - bit 8 sets when data count meets or exceeds threshold, clears on read
// - bits 7:4 hold the error threshold, reset 0001, counted against
// - bits 3:0 hold the data threshold, reset 0001, governing automatic power-up
// - counters return to zero after about two seconds without data events
//
// Chosen here: the APB register port and the address map.
module energy_detect_power_control #(
    parameter int TIMEOUT_CYCLES = energy_detect_pkg::TIMEOUT_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [energy_detect_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic energy_data_event,
    input wire logic energy_error_event,
    input wire logic energy_on_line,
    output logic line_power_up,
    output logic data_pulse,
    output logic power_up_start,
    output logic power_down_start,
    output logic irq
);
    import energy_detect_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic auto_up;
        logic auto_down;
        logic manual;
        logic burst_dis;
        logic [THR_W-1:0] err_thr;
        logic [THR_W-1:0] data_thr;
        power_state_t power;
        logic line_power_up;
        logic data_pulse;
        logic power_up_start;
        logic power_down_start;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] clear_flags;
    } main_state_t;

    localparam main_state_t MAIN_RESET = '{enable: RESET_ENABLE, auto_up: RESET_AUTO_UP,
        auto_down: RESET_AUTO_DOWN, manual: 1'b0, burst_dis: 1'b0,
        err_thr: RESET_THRESHOLD, data_thr: RESET_THRESHOLD, power: PWR_DOWN,
        line_power_up: 1'b1, data_pulse: 1'b0, power_up_start: 1'b0,
        power_down_start: 1'b0, status: 4'h0, mask: 4'h0, irq: 1'b0,
        prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0, clear_flags: 2'h0};

    main_state_t st;
    main_state_t next_st;
    energy_link_if link();
    logic setup;
    logic rd_ctrl;
    logic wr_ctrl;
    logic manual_write;
    logic pwr_bit;
    logic go_up;
    logic go_down;
    logic [IRQ_W-1:0] w1c;
    logic [IRQ_W-1:0] irq_set;
    logic [15:0] ctrl_view;

    // ----------------------------------------------------------------
    // sub-blocks
    // ----------------------------------------------------------------
    event_threshold_counter #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) counters (
        .clock(clock),
        .resetn(resetn),
        .link(link)
    );

    power_up_pulser pulser (
        .clock(clock),
        .resetn(resetn),
        .link(link)
    );

    // counters and pulser see the decisions of this very cycle, so a stale
    // threshold hit cannot bounce the state straight back up
    assign link.data_event = energy_data_event;
    assign link.error_event = energy_error_event;
    assign link.data_threshold = st.data_thr;
    assign link.error_threshold = st.err_thr;
    assign link.clear_counts = go_up || go_down;
    assign link.clear_flags = st.clear_flags;
    assign link.burst_start = go_up;
    assign link.burst_single = st.burst_dis;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        setup = psel && !penable;
        rd_ctrl = psel && penable && st.pready && !pwrite && (paddr == OFS_CONTROL);
        wr_ctrl = psel && penable && st.pready && pwrite && (paddr == OFS_CONTROL);
        manual_write = wr_ctrl && pstrb[1] && pwdata[BIT_MANUAL];
        pwr_bit = st.enable && (st.power == PWR_UP); // invalid when disabled, shows 0
        ctrl_view = {st.enable, st.auto_up, st.auto_down, st.manual, st.burst_dis,
            pwr_bit, link.error_met, link.data_met, st.err_thr, st.data_thr};
        go_up = 1'b0;
        go_down = 1'b0;
        w1c = '0;

        // apb: answer one cycle after setup, write lands on the access edge
        next_st.pready = setup;
        next_st.pslverr = setup && !((paddr == OFS_CONTROL) || (paddr == OFS_STATUS)
            || (paddr == OFS_MASK));
        if (setup) begin
            unique case (paddr)
                OFS_CONTROL: next_st.prdata = 32'(ctrl_view);
                OFS_STATUS: next_st.prdata = 32'(st.status);
                OFS_MASK: next_st.prdata = 32'(st.mask);
                default: next_st.prdata = 32'h00000000;
            endcase
        end
        // clear only the flags that the finished read actually returned
        next_st.clear_flags = rd_ctrl ? {st.prdata[BIT_ERR_MET], st.prdata[BIT_DATA_MET]}
            : 2'h0;
        if (wr_ctrl && pstrb[1]) begin
            next_st.enable = pwdata[BIT_ENABLE];
            next_st.auto_up = pwdata[BIT_AUTO_UP];
            next_st.auto_down = pwdata[BIT_AUTO_DOWN];
            next_st.burst_dis = pwdata[BIT_BURST_DIS];
        end
        if (wr_ctrl && pstrb[0]) begin
            next_st.err_thr = pwdata[ERR_THR_LSB +: THR_W];
            next_st.data_thr = pwdata[DATA_THR_LSB +: THR_W];
        end
        if (psel && penable && st.pready && pwrite && pstrb[0]) begin
            if (paddr == OFS_STATUS) begin
                w1c = pwdata[IRQ_W-1:0];
            end
            if (paddr == OFS_MASK) begin
                next_st.mask = pwdata[IRQ_W-1:0];
            end
        end

        // power state; manual requests outrank the automatic paths
        if (st.enable) begin
            if (st.manual) begin
                go_up = st.power == PWR_DOWN;
                go_down = st.power == PWR_UP;
            end else begin
                unique case (st.power)
                    PWR_DOWN: go_up = st.auto_up && link.data_reached;
                    PWR_UP: go_down = st.auto_down && !energy_on_line;
                endcase
            end
        end
        if (go_up) begin
            next_st.power = PWR_UP;
        end
        if (go_down) begin
            next_st.power = PWR_DOWN;
        end
        // consumed request clears, a fresh write the same cycle wins
        next_st.manual = manual_write;
        next_st.power_up_start = go_up;
        next_st.power_down_start = go_down;
        next_st.line_power_up = !next_st.enable || (next_st.power == PWR_UP);
        next_st.data_pulse = link.pulse_out;

        // sticky interrupt status, set wins over write-one-to-clear
        irq_set = '0;
        irq_set[IRQ_POWER_UP] = go_up;
        irq_set[IRQ_POWER_DOWN] = go_down;
        irq_set[IRQ_DATA_MET] = link.data_met_set;
        irq_set[IRQ_ERR_MET] = link.error_met_set; // informational only
        next_st.status = (st.status & ~w1c) | irq_set;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= MAIN_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign line_power_up = st.line_power_up;
    assign data_pulse = st.data_pulse;
    assign power_up_start = st.power_up_start;
    assign power_down_start = st.power_down_start;
    assign irq = st.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // pulse tally per burst, read only by the checks
    logic pulse_prev;
    logic [3:0] pulse_rises;
    logic burst_single_seen;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pulse_prev <= 1'b0;
            pulse_rises <= 4'h0;
            burst_single_seen <= 1'b0;
        end else begin
            pulse_prev <= link.pulse_out;
            if (link.burst_start && !link.burst_busy) begin
                pulse_rises <= 4'h0;
                burst_single_seen <= st.burst_dis;
            end else if (link.pulse_out && !pulse_prev) begin
                pulse_rises <= pulse_rises + 4'h1;
            end
        end
    end

    AST_DISABLED_HOLDS: assert property (!st.enable |=> $stable(st.power))
        else $error("power state changed while disabled");
    AST_AUTO_UP: assert property (st.enable && st.auto_up && !st.manual
        && st.power == PWR_DOWN && link.data_reached |=> st.power == PWR_UP && power_up_start)
        else $error("automatic power-up missed");
    AST_AUTO_DOWN: assert property (st.enable && st.auto_down && !st.manual
        && st.power == PWR_UP && !energy_on_line |=> st.power == PWR_DOWN && power_down_start)
        else $error("automatic power-down missed");
    AST_MANUAL_CLEARS: assert property (st.manual && !manual_write |=> !st.manual)
        else $error("manual bit did not self-clear");
    AST_MANUAL_TOGGLES: assert property (st.enable && st.manual && st.power == PWR_DOWN
        |=> st.power == PWR_UP ##1 link.burst_busy)
        else $error("manual request did not toggle power up");
    AST_NO_AUTO: assert property (st.enable && !st.auto_up && !st.auto_down && !st.manual
        |=> $stable(st.power))
        else $error("power changed without a request");
    AST_BURST_COUNT: assert property ($fell(link.burst_busy)
        |-> pulse_rises == (burst_single_seen ? SINGLE_LEN : BURST_LEN))
        else $error("wrong number of pulses in burst");
    AST_PWR_STATE_READ: assert property (setup && !pwrite && paddr == OFS_CONTROL
        |=> prdata[BIT_PWR_STATE] == $past(pwr_bit) && pready)
        else $error("power state bit read wrong");
    AST_COR_DATA: assert property (rd_ctrl && st.prdata[BIT_DATA_MET]
        |=> ##1 (!link.data_met || link.data_met_set))
        else $error("data flag not cleared by read");
    AST_COR_ERR: assert property (rd_ctrl && st.prdata[BIT_ERR_MET]
        |=> ##1 (!link.error_met || link.error_met_set))
        else $error("error flag not cleared by read");
    AST_IRQ_LEVEL: assert property (irq == |(st.status & st.mask))
        else $error("interrupt level mismatch");
    // last cycle of each pulse phase, for the burst shape checks
    localparam int PULSE_HIGH_LAST = PULSE_HIGH_CYCLES - 1;
    localparam int PULSE_GAP_LAST = PULSE_GAP_CYCLES - 1;
    AST_PULSE_HIGH: assert property ($rose(link.pulse_out)
        |-> ##PULSE_HIGH_LAST link.pulse_out ##1 !link.pulse_out)
        else $error("data pulse high time wrong");
    AST_PULSE_GAP: assert property ($fell(link.pulse_out) && link.burst_busy
        |-> ##PULSE_GAP_LAST !link.pulse_out ##1 link.pulse_out)
        else $error("gap between data pulses wrong");
    AST_MANUAL_DOWN: assert property (st.enable && st.manual && st.power == PWR_UP
        |=> st.power == PWR_DOWN && power_down_start)
        else $error("manual request did not toggle power down");
    AST_UP_NEEDS_CAUSE: assert property (st.power == PWR_DOWN && !st.manual
        && !link.data_reached |=> st.power == PWR_DOWN)
        else $error("power-up without data threshold or request");
    AST_DOWN_NEEDS_CAUSE: assert property (st.power == PWR_UP && !st.manual
        && (energy_on_line || !st.auto_down) |=> st.power == PWR_UP)
        else $error("power-down without request or quiet line");
    AST_UNMAPPED: assert property (setup && paddr != OFS_CONTROL && paddr != OFS_STATUS
        && paddr != OFS_MASK |=> pready && pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    COV_AUTO_UP: cover property (power_up_start && !$past(st.manual));
    COV_MANUAL_DOWN: cover property ($past(st.manual) && power_down_start);
    COV_FULL_BURST: cover property ($fell(link.burst_busy) && pulse_rises == BURST_LEN);
    COV_IRQ: cover property ($rose(irq));
    COV_SINGLE_BURST: cover property ($fell(link.burst_busy) && pulse_rises == SINGLE_LEN);
endmodule

// file: energy_detect_pkg.sv
package energy_detect_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int TIMEOUT_MS = 2000;
    // quiet-line timeout, longest time so rounded down
    localparam int TIMEOUT_CYCLES_DEF = TIMEOUT_MS * 1000 * CLOCK_MHZ;
    localparam int TIMER_W = 29;
    localparam int PULSE_HIGH_NS = 100;
    localparam int PULSE_GAP_NS = 400;
    // least times, rounded up to whole cycles
    localparam int PULSE_HIGH_CYCLES = (PULSE_HIGH_NS * CLOCK_MHZ + 999) / 1000;
    localparam int PULSE_GAP_CYCLES = (PULSE_GAP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int PULSE_CNT_W = 8;
    localparam logic [3:0] BURST_LEN = 4'h4;
    localparam logic [3:0] SINGLE_LEN = 4'h1;

    // ----------------------------------------------------------------
    // control register layout
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE = 15;
    localparam int BIT_AUTO_UP = 14;
    localparam int BIT_AUTO_DOWN = 13;
    localparam int BIT_MANUAL = 12;
    localparam int BIT_BURST_DIS = 11;
    localparam int BIT_PWR_STATE = 10;
    localparam int BIT_ERR_MET = 9;
    localparam int BIT_DATA_MET = 8;
    localparam int THR_W = 4;
    localparam int ERR_THR_LSB = 4;
    localparam int DATA_THR_LSB = 0;
    localparam logic [3:0] COUNT_MAX = 4'hF;
    localparam logic RESET_ENABLE = 1'b0;
    localparam logic RESET_AUTO_UP = 1'b1;
    localparam logic RESET_AUTO_DOWN = 1'b1;
    localparam logic [3:0] RESET_THRESHOLD = 4'h1;

    // ----------------------------------------------------------------
    // apb map and interrupt bits
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam int IRQ_W = 4;
    localparam int IRQ_POWER_UP = 0;
    localparam int IRQ_POWER_DOWN = 1;
    localparam int IRQ_DATA_MET = 2;
    localparam int IRQ_ERR_MET = 3;

    typedef enum logic [1:0] {
        PWR_DOWN = 2'b01,
        PWR_UP = 2'b10
    } power_state_t;

    typedef enum logic [2:0] {
        PLS_IDLE = 3'b001,
        PLS_HIGH = 3'b010,
        PLS_GAP = 3'b100
    } pulse_state_t;
endpackage

// file: energy_link_if.sv
// ----------------------------------------------------------------
// link between power control, event counters and pulse generator
// ----------------------------------------------------------------
interface energy_link_if;
    import energy_detect_pkg::*;
    logic data_event;
    logic error_event;
    logic [THR_W-1:0] data_threshold;
    logic [THR_W-1:0] error_threshold;
    logic clear_counts;
    logic [1:0] clear_flags;
    logic data_reached;
    logic data_met;
    logic error_met;
    logic data_met_set;
    logic error_met_set;
    logic burst_start;
    logic burst_single;
    logic pulse_out;
    logic burst_busy;

    modport counter(
        input data_event, error_event, data_threshold, error_threshold,
        input clear_counts, clear_flags,
        output data_reached, data_met, error_met, data_met_set, error_met_set
    );
    modport pulser(
        input burst_start, burst_single,
        output pulse_out, burst_busy
    );
    modport control(
        output data_event, error_event, data_threshold, error_threshold,
        output clear_counts, clear_flags, burst_start, burst_single,
        input data_reached, data_met, error_met, data_met_set, error_met_set,
        input pulse_out, burst_busy
    );
endinterface

// file: event_threshold_counter.sv
module event_threshold_counter #(
    parameter int TIMEOUT_CYCLES = energy_detect_pkg::TIMEOUT_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic resetn,
    energy_link_if.counter link
);
    import energy_detect_pkg::*;

    typedef struct packed {
        logic [THR_W-1:0] data_count;
        logic [THR_W-1:0] error_count;
        logic [TIMER_W-1:0] timer;
        logic data_reached;
        logic data_met;
        logic error_met;
        logic data_met_set;
        logic error_met_set;
    } count_state_t;

    count_state_t st;
    count_state_t next_st;
    logic data_set;
    logic error_set;

    // counting, quiet-line timeout and sticky threshold flags
    always_comb begin
        next_st = st;
        if (link.clear_counts) begin
            next_st.data_count = '0;
            next_st.error_count = '0;
        end
        if (link.data_event) begin
            next_st.timer = '0; // restart on every data event
            if (next_st.data_count != COUNT_MAX) begin
                next_st.data_count = next_st.data_count + 4'h1;
            end
        end else if (st.timer == TIMER_W'(TIMEOUT_CYCLES - 1)) begin
            next_st.timer = '0;
            next_st.data_count = '0; // quiet line empties both counters
            next_st.error_count = '0;
        end else begin
            next_st.timer = st.timer + 29'h1;
        end
        if (link.error_event && next_st.error_count != COUNT_MAX) begin
            next_st.error_count = next_st.error_count + 4'h1;
        end
        // saturating counts, so a threshold of 15 is still reachable
        data_set = link.data_event && (next_st.data_count >= link.data_threshold);
        error_set = link.error_event && (next_st.error_count >= link.error_threshold);
        next_st.data_reached = next_st.data_count >= link.data_threshold;
        // a new event wins over a clear in the same cycle
        next_st.data_met = data_set || (st.data_met && !link.clear_flags[0]);
        next_st.error_met = error_set || (st.error_met && !link.clear_flags[1]);
        next_st.data_met_set = data_set;
        next_st.error_met_set = error_set;
    end

    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.data_reached = st.data_reached;
    assign link.data_met = st.data_met;
    assign link.error_met = st.error_met;
    assign link.data_met_set = st.data_met_set;
    assign link.error_met_set = st.error_met_set;
endmodule

// file: power_up_pulser.sv
module power_up_pulser (
    input wire logic clock,
    input wire logic resetn,
    energy_link_if.pulser link
);
    import energy_detect_pkg::*;

    typedef struct packed {
        pulse_state_t phase;
        logic [3:0] remaining;
        logic [PULSE_CNT_W-1:0] cnt;
        logic pulse_out;
        logic busy;
    } pulse_st_t;

    localparam pulse_st_t PULSE_RESET = '{phase: PLS_IDLE, remaining: 4'h0,
        cnt: 8'h00, pulse_out: 1'b0, busy: 1'b0};

    pulse_st_t st;
    pulse_st_t next_st;

    // burst sequencer; a start while busy is ignored
    always_comb begin
        next_st = st;
        unique case (st.phase)
            PLS_IDLE: begin
                if (link.burst_start) begin
                    next_st.remaining = link.burst_single ? SINGLE_LEN : BURST_LEN;
                    next_st.phase = PLS_HIGH;
                    next_st.cnt = '0;
                    next_st.pulse_out = 1'b1;
                    next_st.busy = 1'b1;
                end
            end
            PLS_HIGH: begin
                next_st.cnt = st.cnt + 8'h01;
                if (st.cnt == PULSE_CNT_W'(PULSE_HIGH_CYCLES - 1)) begin
                    next_st.cnt = '0;
                    next_st.pulse_out = 1'b0;
                    next_st.remaining = st.remaining - 4'h1;
                    if (st.remaining == SINGLE_LEN) begin
                        next_st.phase = PLS_IDLE;
                        next_st.busy = 1'b0;
                    end else begin
                        next_st.phase = PLS_GAP;
                    end
                end
            end
            PLS_GAP: begin
                next_st.cnt = st.cnt + 8'h01;
                if (st.cnt == PULSE_CNT_W'(PULSE_GAP_CYCLES - 1)) begin
                    next_st.cnt = '0;
                    next_st.pulse_out = 1'b1;
                    next_st.phase = PLS_HIGH;
                end
            end
            default: next_st = PULSE_RESET;
        endcase
    end

    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= PULSE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign link.pulse_out = st.pulse_out;
    assign link.burst_busy = st.busy;
endmodule

// file: link_partner.sv
// ----------------------------------------------------------------
// remote partner on the cable side
// ----------------------------------------------------------------
module link_partner (
    output logic energy_data_event,
    output logic energy_error_event,
    output logic energy_on_line,
    input wire logic clock
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet events, energy present at start
    initial begin
        energy_data_event = 1'b0;
        energy_error_event = 1'b0;
        energy_on_line = 1'b1;
    end
    // one-cycle pulses with a free cycle between, so none merge
    task automatic send(input int n, input bit err);
        repeat (n) begin
            @(posedge clock);
            energy_data_event <= !err;
            energy_error_event <= err;
            @(posedge clock);
            energy_data_event <= 1'b0;
            energy_error_event <= 1'b0;
        end
    endtask
    // line energy level
    task automatic line(input bit on);
        @(posedge clock);
        energy_on_line <= on;
    endtask
endmodule

// file: test_energy_detect_power_control.sv
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module test_energy_detect_power_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, ded, dee, don, lpu, data_pulse, pus, pds, irq, last, last_err;
    int errors = 0, compares = 0, cycles = 0, ups = 0, downs = 0, pulses = 0;
    energy_detect_power_control #(.TIMEOUT_CYCLES(200)) u_energy_detect_power_control (
        .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .energy_data_event(ded), .energy_error_event(dee),
        .energy_on_line(don), .line_power_up(lpu), .data_pulse(data_pulse),
        .power_up_start(pus), .power_down_start(pds), .irq(irq));
    link_partner u_link_partner (.energy_data_event(ded), .energy_error_event(dee),
        .energy_on_line(don), .clock(clock));
    // 5 ns clock
    initial begin
        forever #2.5 clock = ~clock;
    end
    // power starts, pulse rises and a hang limit
    always @(posedge clock) begin
        cycles <= cycles + 1;
        ups <= ups + (pus === 1'b1);
        downs <= downs + (pds === 1'b1);
        pulses <= pulses + (data_pulse === 1'b1 && last !== 1'b1);
        last <= data_pulse;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one transfer; request held until pready is sampled high
    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic t_reset();
        rd("control", 12'h000, 32'h0000_6011);
        chk("line power idle", 32'h1, {31'h0, lpu});
        rd("unmapped", 12'h00C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, last_err});
        $display("test reset done");
    endtask
    task automatic t_manual();
        wr(12'h000, 32'h0000_8011);
        u_link_partner.send(3, 1'b0);
        repeat (5) @(posedge clock);
        chk("no auto up", 32'h0, ups);
        wr(12'h000, 32'h0000_9011);
        repeat (5) @(posedge clock);
        chk("manual up", 32'h1, ups);
        rd("control up", 12'h000, 32'h0000_8511);
        repeat (450) @(posedge clock);
        chk("burst", 32'h4, pulses);
        rd("flag cleared", 12'h000, 32'h0000_8411);
        $display("test manual done");
    endtask
    task automatic t_burst();
        wr(12'h000, 32'h0000_9811);
        repeat (5) @(posedge clock);
        chk("manual down", 32'h1, downs);
        chk("line power down", 32'h0, {31'h0, lpu});
        rd("control down", 12'h000, 32'h0000_8811);
        wr(12'h000, 32'h0000_9811);
        repeat (450) @(posedge clock);
        chk("single", 32'h5, pulses);
        $display("test burst done");
    endtask
    task automatic t_auto();
        wr(12'h004, 32'hF);
        wr(12'h008, 32'h1);
        repeat (2) @(posedge clock);
        chk("irq idle", 32'h0, {31'h0, irq});
        wr(12'h000, 32'h0000_E023);
        u_link_partner.line(1'b0);
        repeat (5) @(posedge clock);
        chk("auto down", 32'h2, downs);
        u_link_partner.line(1'b1);
        u_link_partner.send(2, 1'b0);
        repeat (250) @(posedge clock);
        u_link_partner.send(2, 1'b0);
        repeat (5) @(posedge clock);
        chk("timeout", 32'h2, ups);
        u_link_partner.send(1, 1'b0);
        repeat (5) @(posedge clock);
        chk("auto up", 32'h3, ups);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(12'h004, 32'h1);
        repeat (3) @(posedge clock);
        chk("irq clear", 32'h0, {31'h0, irq});
        u_link_partner.send(2, 1'b1);
        repeat (5) @(posedge clock);
        rd("error flag", 12'h000, 32'h0000_E723);
        chk("no power act", 32'h5, ups + downs);
        rd("flags read", 12'h000, 32'h0000_E423);
        $display("test auto done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_manual();
        t_burst();
        t_auto();
        close_out();
    end
endmodule
